// *** prli_top.sv ***
// Proximity and ambient-light interrupt, flag and wait-time logic
`timescale 1ns/10ps
`include "prli_cfg.svh"

module prli_top import prli_pkg::*; #(
  parameter int unsigned WAIT_STEP_CYCLES = (`PRLI_WAIT_STEP_US * 1000) / `PRLI_CLK_PERIOD_NS
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [15:0] PROX_COUNT,
  input wire logic PROX_VALID,
  input wire logic PROX_PERSIST_4,
  input wire logic [15:0] LIGHT_COUNT,
  input wire logic LIGHT_VALID,
  input wire logic LIGHT_PERSIST_4,
  input wire logic WAIT_START,
  output logic WAIT_DONE,
  output logic INT_N_O,
  output logic INT_N_OE
);

  localparam logic [31:0] STEP = 32'(WAIT_STEP_CYCLES);

  prli_state_t st_reg;
  prli_state_t st_next;

  prli_pmode_t pmode;
  logic above_hi;
  logic below_lo;
  logic prox_cond;
  logic prox_fire;
  logic light_cond;
  logic light_fire;
  logic flag_mode;
  logic prox_read;
  logic wr_flags;
  logic nf_read;
  logic [1:0] prox_target;
  logic [1:0] light_target;
  logic [31:0] wait_total;

  always_comb begin
    pmode = prli_pmode_t'(st_reg.int_setup[2:0]);
    above_hi = PROX_COUNT > st_reg.prox_high_threshold;
    below_lo = PROX_COUNT < st_reg.prox_low_threshold;
    flag_mode = (pmode == PM_FLAG) || (pmode == PM_FLAG_INV);
    prox_read = REG_RD && ((REG_ADDR == `PRLI_OFS_PCNT_MSB) || (REG_ADDR == `PRLI_OFS_PCNT_LSB));
    wr_flags = REG_WR && (REG_ADDR == `PRLI_OFS_FLAGS);
    prox_target = PROX_PERSIST_4 ? `PRLI_PERSIST_FOUR : `PRLI_PERSIST_ONE;
    light_target = LIGHT_PERSIST_4 ? `PRLI_PERSIST_FOUR : `PRLI_PERSIST_ONE;
    // Qualifying result depends on mode; near/far modes look for the opposite crossing
    case (pmode)
      PM_OFF: prox_cond = 1'b0;
      PM_TOGGLE, PM_FLAG, PM_FLAG_INV: prox_cond = st_reg.near_far_state ? above_hi : below_lo;
      PM_LEGACY: prox_cond = (st_reg.lg_state == LG_WAIT_NEAR) ? above_hi :
                             (st_reg.lg_state == LG_WAIT_FAR) ? below_lo : 1'b0;
      PM_ABOVE: prox_cond = above_hi;
      PM_BELOW: prox_cond = below_lo;
      PM_OUTSIDE: prox_cond = above_hi || below_lo;
      default: prox_cond = 1'b0;
    endcase
    // light window check gated by enable
    light_cond = st_reg.int_setup[`PRLI_BIT_LIGHT_EN] &&
                 ((LIGHT_COUNT > st_reg.light_high_threshold) || (LIGHT_COUNT < st_reg.light_low_threshold));
    prox_fire = PROX_VALID && prox_cond && (st_reg.prox_persist_cnt >= prox_target);
    light_fire = LIGHT_VALID && light_cond && (st_reg.light_persist_cnt >= light_target);
    case (pmode)
      PM_TOGGLE, PM_FLAG, PM_FLAG_INV, PM_LEGACY: nf_read = st_reg.near_far_state;
      default: nf_read = 1'b1;
    endcase
    wait_total = (32'(st_reg.wait_code) + 32'h0000_0001) * STEP;
  end

  always_comb begin
    st_next = st_reg;
    st_next.wait_done = 1'b0;

    if (REG_WR) begin
      case (REG_ADDR)
        `PRLI_OFS_INT_SETUP: st_next.int_setup = REG_WDATA;
        `PRLI_OFS_WAIT: st_next.wait_code = REG_WDATA;
        `PRLI_OFS_PTH_HI_MSB: st_next.prox_high_threshold[15:8] = REG_WDATA;
        `PRLI_OFS_PTH_HI_LSB: st_next.prox_high_threshold[7:0] = REG_WDATA;
        `PRLI_OFS_PTH_LO_MSB: st_next.prox_low_threshold[15:8] = REG_WDATA;
        `PRLI_OFS_PTH_LO_LSB: st_next.prox_low_threshold[7:0] = REG_WDATA;
        `PRLI_OFS_LTH_HI_MSB: st_next.light_high_threshold[15:8] = REG_WDATA;
        `PRLI_OFS_LTH_HI_LSB: st_next.light_high_threshold[7:0] = REG_WDATA;
        `PRLI_OFS_LTH_LO_MSB: st_next.light_low_threshold[15:8] = REG_WDATA;
        `PRLI_OFS_LTH_LO_LSB: st_next.light_low_threshold[7:0] = REG_WDATA;
        default: ;
      endcase
    end

    // clear only by writing zero, set wins below
    if (wr_flags && !REG_WDATA[`PRLI_BIT_PFLAG]) begin
      st_next.prox_irq_flag = 1'b0;
    end
    // host zero write clears light flag
    if (wr_flags && !REG_WDATA[`PRLI_BIT_LFLAG]) begin
      st_next.light_irq_flag = 1'b0;
    end

    // consecutive count, restarts on a non-qualifying result
    if (PROX_VALID) begin
      if (!prox_cond || prox_fire) begin
        st_next.prox_persist_cnt = 2'h0;
      end else begin
        st_next.prox_persist_cnt = st_reg.prox_persist_cnt + 2'h1;
      end
    end
    if (LIGHT_VALID) begin
      if (!light_cond || light_fire) begin
        st_next.light_persist_cnt = 2'h0;
      end else begin
        st_next.light_persist_cnt = st_reg.light_persist_cnt + 2'h1;
      end
    end

    case (pmode)
      PM_TOGGLE, PM_FLAG, PM_FLAG_INV: begin
        if (prox_fire) begin
          st_next.near_far_state = ~st_reg.near_far_state;
          // interrupt on each change; level modes raise no flag
          if (pmode == PM_TOGGLE) begin
            st_next.prox_irq_flag = 1'b1;
          end
        end
      end
      // legacy sequence, host count read advances it
      PM_LEGACY: begin
        case (st_reg.lg_state)
          LG_WAIT_NEAR: if (prox_fire) begin
            st_next.prox_irq_flag = 1'b1;
            st_next.near_far_state = 1'b1;
            st_next.lg_state = LG_READ_NEAR;
          end
          LG_READ_NEAR: if (prox_read) begin
            st_next.lg_state = LG_WAIT_FAR;
          end
          LG_WAIT_FAR: if (prox_fire) begin
            st_next.prox_irq_flag = 1'b1;
            st_next.near_far_state = 1'b0;
            st_next.lg_state = LG_READ_FAR;
          end
          LG_READ_FAR: if (prox_read) begin
            st_next.lg_state = LG_WAIT_NEAR;
          end
          default: st_next.lg_state = LG_WAIT_NEAR;
        endcase
      end
      // every result that meets the persistence count re-raises the flag
      PM_ABOVE, PM_BELOW, PM_OUTSIDE: begin
        if (prox_fire) begin
          st_next.prox_irq_flag = 1'b1;
        end
        st_next.near_far_state = 1'b1;
      end
      default: st_next.near_far_state = 1'b1;
    endcase
    // Sequence restarts whenever the legacy mode is left
    if (pmode != PM_LEGACY) begin
      st_next.lg_state = LG_WAIT_NEAR;
    end

    if (light_fire) begin
      st_next.light_irq_flag = 1'b1;
    end

    // wait of (code + 1) steps
    if (WAIT_START) begin
      st_next.wait_busy = 1'b1;
      st_next.wait_cnt = 32'h0000_0001;
    end else if (st_reg.wait_busy) begin
      if (st_reg.wait_cnt >= wait_total) begin
        st_next.wait_busy = 1'b0;
        st_next.wait_done = 1'b1;
      end else begin
        st_next.wait_cnt = st_reg.wait_cnt + 32'h0000_0001;
      end
    end

    // Pin follows the next-state flags (next near/far state in flag modes), so it changes in the same cycle as them
    if (flag_mode) begin
      // level flag from comparison only; 010 drives near as high
      st_next.int_oe_n = (pmode == PM_FLAG) ? ~st_next.near_far_state : st_next.near_far_state;
    end else if (st_reg.int_setup[`PRLI_BIT_COMBINE]) begin
      st_next.int_oe_n = !(st_next.prox_irq_flag && st_next.light_irq_flag);
    end else begin
      st_next.int_oe_n = !(st_next.prox_irq_flag || st_next.light_irq_flag);
    end

    if (REG_RD) begin
      case (REG_ADDR)
        `PRLI_OFS_INT_SETUP: st_next.rdata = st_reg.int_setup;
        `PRLI_OFS_WAIT: st_next.rdata = st_reg.wait_code;
        `PRLI_OFS_PTH_HI_MSB: st_next.rdata = st_reg.prox_high_threshold[15:8];
        `PRLI_OFS_PTH_HI_LSB: st_next.rdata = st_reg.prox_high_threshold[7:0];
        `PRLI_OFS_PTH_LO_MSB: st_next.rdata = st_reg.prox_low_threshold[15:8];
        `PRLI_OFS_PTH_LO_LSB: st_next.rdata = st_reg.prox_low_threshold[7:0];
        `PRLI_OFS_LTH_HI_MSB: st_next.rdata = st_reg.light_high_threshold[15:8];
        `PRLI_OFS_LTH_HI_LSB: st_next.rdata = st_reg.light_high_threshold[7:0];
        `PRLI_OFS_LTH_LO_MSB: st_next.rdata = st_reg.light_low_threshold[15:8];
        `PRLI_OFS_LTH_LO_LSB: st_next.rdata = st_reg.light_low_threshold[7:0];
        `PRLI_OFS_FLAGS: begin
          st_next.rdata = `PRLI_RST_BYTE;
          st_next.rdata[`PRLI_BIT_NF] = nf_read;
          st_next.rdata[`PRLI_BIT_PFLAG] = st_reg.prox_irq_flag;
          st_next.rdata[`PRLI_BIT_LFLAG] = st_reg.light_irq_flag;
        end
        `PRLI_OFS_PCNT_MSB: st_next.rdata = PROX_COUNT[15:8];
        `PRLI_OFS_PCNT_LSB: st_next.rdata = PROX_COUNT[7:0];
        `PRLI_OFS_LCNT_MSB: st_next.rdata = LIGHT_COUNT[15:8];
        `PRLI_OFS_LCNT_LSB: st_next.rdata = LIGHT_COUNT[7:0];
        default: st_next.rdata = `PRLI_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_reg.int_setup <= `PRLI_RST_BYTE;
      st_reg.wait_code <= `PRLI_RST_BYTE;
      st_reg.prox_high_threshold <= `PRLI_RST_THI;
      st_reg.prox_low_threshold <= `PRLI_RST_WORD;
      st_reg.light_high_threshold <= `PRLI_RST_THI;
      st_reg.light_low_threshold <= `PRLI_RST_WORD;
      st_reg.near_far_state <= 1'b1;
      st_reg.prox_irq_flag <= 1'b0;
      st_reg.light_irq_flag <= 1'b0;
      st_reg.prox_persist_cnt <= 2'h0;
      st_reg.light_persist_cnt <= 2'h0;
      st_reg.lg_state <= LG_WAIT_NEAR;
      st_reg.wait_cnt <= 32'h0000_0000;
      st_reg.wait_busy <= 1'b0;
      st_reg.wait_done <= 1'b0;
      st_reg.int_oe_n <= 1'b1;
      st_reg.rdata <= `PRLI_RST_BYTE;
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  // open drain: data always low, enable low pulls the pin
  assign INT_N_O = 1'b0;
  assign INT_N_OE = st_reg.int_oe_n;
  assign REG_RDATA = st_reg.rdata;
  assign WAIT_DONE = st_reg.wait_done;

endmodule // prli_top

// *** prli_cfg.svh ***
// Register offsets, field positions, reset values and timing figures of the interrupt logic
`ifndef PRLI_CFG_SVH
`define PRLI_CFG_SVH

`define PRLI_OFS_INT_SETUP 8'h04
`define PRLI_OFS_WAIT 8'h05
`define PRLI_OFS_PTH_HI_MSB 8'h06
`define PRLI_OFS_PTH_HI_LSB 8'h07
`define PRLI_OFS_PTH_LO_MSB 8'h08
`define PRLI_OFS_PTH_LO_LSB 8'h09
`define PRLI_OFS_LTH_HI_MSB 8'h0A
`define PRLI_OFS_LTH_HI_LSB 8'h0B
`define PRLI_OFS_LTH_LO_MSB 8'h0C
`define PRLI_OFS_LTH_LO_LSB 8'h0D
`define PRLI_OFS_FLAGS 8'h10
`define PRLI_OFS_PCNT_MSB 8'h11
`define PRLI_OFS_PCNT_LSB 8'h12
`define PRLI_OFS_LCNT_MSB 8'h13
`define PRLI_OFS_LCNT_LSB 8'h14

`define PRLI_BIT_LIGHT_EN 3
`define PRLI_BIT_RSVD 4
`define PRLI_BIT_COMBINE 7
`define PRLI_BIT_NF 0
`define PRLI_BIT_PFLAG 4
`define PRLI_BIT_LFLAG 5

`define PRLI_RST_BYTE 8'h00
`define PRLI_RST_WORD 16'h0000
`define PRLI_RST_THI 16'hFFFF

`define PRLI_PERSIST_ONE 2'h0
`define PRLI_PERSIST_FOUR 2'h3

`define PRLI_CLK_PERIOD_NS 4
`define PRLI_WAIT_STEP_US 5930

`endif

// *** prli_pkg.sv ***
// Types shared by the proximity and light interrupt logic
package prli_pkg;

  typedef enum logic [2:0] {
    PM_OFF = 3'h0,
    PM_TOGGLE = 3'h1,
    PM_FLAG = 3'h2,
    PM_FLAG_INV = 3'h3,
    PM_LEGACY = 3'h4,
    PM_ABOVE = 3'h5,
    PM_BELOW = 3'h6,
    PM_OUTSIDE = 3'h7
  } prli_pmode_t;

  typedef enum logic [1:0] {
    LG_WAIT_NEAR,
    LG_READ_NEAR,
    LG_WAIT_FAR,
    LG_READ_FAR
  } prli_lg_t;

  typedef struct packed {
    logic [7:0] int_setup;
    logic [7:0] wait_code;
    logic [15:0] prox_high_threshold;
    logic [15:0] prox_low_threshold;
    logic [15:0] light_high_threshold;
    logic [15:0] light_low_threshold;
    logic near_far_state;
    logic prox_irq_flag;
    logic light_irq_flag;
    logic [1:0] prox_persist_cnt;
    logic [1:0] light_persist_cnt;
    prli_lg_t lg_state;
    logic [31:0] wait_cnt;
    logic wait_busy;
    logic wait_done;
    logic int_oe_n;
    logic [7:0] rdata;
  } prli_state_t;

endpackage

// *** prli_top_sva.sv ***
// Port-level assertions for the proximity and light interrupt logic
`timescale 1ns/10ps
module prli_top_chk (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic [15:0] PROX_COUNT,
  input wire logic PROX_VALID,
  input wire logic PROX_PERSIST_4,
  input wire logic WAIT_DONE,
  input wire logic INT_N_O,
  input wire logic INT_N_OE
);
  logic [7:0] setup_reg;
  logic [15:0] phi_reg;
  logic [15:0] plo_reg;
  logic one_hit;
  // Only single-result persistence lets a result decide the pin at once
  assign one_hit = CE && PROX_VALID && !PROX_PERSIST_4;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      setup_reg <= 8'h00;
      phi_reg <= 16'hFFFF;
      plo_reg <= 16'h0000;
    end else if (CE && REG_WR) begin
      case (REG_ADDR)
        8'h04: setup_reg <= REG_WDATA;
        8'h06: phi_reg[15:8] <= REG_WDATA;
        8'h07: phi_reg[7:0] <= REG_WDATA;
        8'h08: plo_reg[15:8] <= REG_WDATA;
        8'h09: plo_reg[7:0] <= REG_WDATA;
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  sequence rd_sq;
    CE && REG_RD;
  endsequence
  pin_drive_a: assert property (INT_N_O == 1'b0) else $error("pin data not low");
  wait_pulse_a: assert property (WAIT_DONE |=> !WAIT_DONE) else $error("wait done too long");
  rd_hold_a: assert property (!(CE && REG_RD) |=> $stable(REG_RDATA)) else $error("read data moved");
  unmapped_rd_a: assert property (rd_sq ##0 (REG_ADDR > 8'h14) |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  flag_bits_a: assert property (rd_sq ##0 (REG_ADDR == 8'h10) |=> REG_RDATA[7:6] == 2'b00 && REG_RDATA[3:1] == 3'b000)
    else $error("flag spare bits set");
  above_irq_a: assert property (one_hit && setup_reg == 8'h05 && PROX_COUNT > phi_reg |=> !INT_N_OE)
    else $error("no pin above high");
  below_irq_a: assert property (one_hit && setup_reg == 8'h06 && PROX_COUNT < plo_reg |=> !INT_N_OE)
    else $error("no pin below low");
  near_flag_a: assert property (one_hit && setup_reg == 8'h02 && PROX_COUNT > phi_reg |=> INT_N_OE)
    else $error("level flag not high");
  near_inv_a: assert property (one_hit && setup_reg == 8'h03 && PROX_COUNT > phi_reg |=> !INT_N_OE)
    else $error("inverted flag not low");
endmodule // prli_top_chk

bind prli_top prli_top_chk chk_i (.MCLK(MCLK), .RESETN(RESETN), .CE(CE), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PROX_COUNT(PROX_COUNT),
  .PROX_VALID(PROX_VALID), .PROX_PERSIST_4(PROX_PERSIST_4), .WAIT_DONE(WAIT_DONE), .INT_N_O(INT_N_O),
  .INT_N_OE(INT_N_OE));

// *** prli_host_pin.sv ***
// Host side of the open-drain interrupt line
`timescale 1ns/10ps
module prli_host_pin (
  input wire logic int_oe_n,
  input wire logic int_o,
  output logic int_level
);
  // pull-up when released
  // A released line reads the pull-up, never a stale low
  assign int_level = int_oe_n ? 1'b1 : int_o;
endmodule // prli_host_pin

// *** prox_light_interrupt_logic_bench.sv ***
// Register-level bench for the proximity and light interrupt logic
`timescale 1ns/10ps
module prox_light_interrupt_logic_bench;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pv = 1'b0;
  logic lv = 1'b0;
  logic p4 = 1'b0;
  logic ws = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [15:0] lc = 16'h0000;
  logic [7:0] rdata;
  logic wdone;
  logic int_o;
  logic int_oe_n;
  logic pin;
  logic hit;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] ra [0:10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h10};
  logic [7:0] re [0:10] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h01};
  prli_top #(.WAIT_STEP_CYCLES(2)) dut (.MCLK(mclk), .RESETN(resetn), .CE(1'b1), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PROX_COUNT(pc), .PROX_VALID(pv),
    .PROX_PERSIST_4(p4), .LIGHT_COUNT(lc), .LIGHT_VALID(lv), .LIGHT_PERSIST_4(1'b0), .WAIT_START(ws),
    .WAIT_DONE(wdone), .INT_N_O(int_o), .INT_N_OE(int_oe_n));
  prli_host_pin host (.int_oe_n(int_oe_n), .int_o(int_o), .int_level(pin));
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs move 1 ns after the edge so the design never races them
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk(rdata, exp);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr8(a, v[15:8]);
    wr8(a + 8'h01, v[7:0]);
  endtask
  task automatic pres(input logic [15:0] c);
    pc = c;
    pv = 1'b1;
    tick(1);
    pv = 1'b0;
  endtask
  task automatic lres(input logic [15:0] c);
    lc = c;
    lv = 1'b1;
    tick(1);
    lv = 1'b0;
  endtask
  initial begin
    tick(12);
    resetn = 1'b1;
    for (int i = 0; i < 11; i++) rd8(ra[i], re[i]);
    chk(pin, 1'b1);
    wr8(8'h0E, 8'hAA);
    rd8(8'h0E, 8'h00);
    lc = 16'hBEEF;
    wr8(8'h13, 8'h00);
    rd8(8'h13, 8'hBE);
    rd8(8'h14, 8'hEF);
    wr16(8'h06, 16'h0100);
    wr16(8'h08, 16'h0050);
    rd8(8'h06, 8'h01);
    rd8(8'h09, 8'h50);
    wr8(8'h04, 8'h01);
    pres(16'h0200);
    chk(pin, 1'b0);
    rd8(8'h10, 8'h10);
    wr8(8'h10, 8'h00);
    pres(16'h0200);
    rd8(8'h10, 8'h00);
    pres(16'h0040);
    rd8(8'h10, 8'h11);
    wr8(8'h10, 8'h00);
    // light source stays off while the pin is a level flag
    wr8(8'h04, 8'h02);
    tick(2);
    chk(pin, 1'b0);
    pres(16'h0200);
    chk(pin, 1'b1);
    wr8(8'h10, 8'h00);
    tick(2);
    chk(pin, 1'b1);
    rd8(8'h10, 8'h00);
    pres(16'h0040);
    chk(pin, 1'b0);
    wr8(8'h04, 8'h03);
    tick(2);
    chk(pin, 1'b1);
    pres(16'h0200);
    chk(pin, 1'b0);
    wr8(8'h04, 8'h00);
    pres(16'h0040);
    pres(16'h0200);
    rd8(8'h10, 8'h01);
    chk(pin, 1'b1);
    for (int m = 5; m < 8; m++) begin
      for (int k = 0; k < 2; k++) begin
        wr8(8'h04, 8'(m));
        pres(k ? 16'h0040 : 16'h0200);
        hit = (m == 7) || (m == 5 && k == 0) || (m == 6 && k == 1);
        chk(pin, !hit);
        rd8(8'h10, {3'b000, hit, 4'h1});
        wr8(8'h10, 8'h00);
        tick(1);
        chk(pin, 1'b1);
      end
    end
    wr8(8'h04, 8'h05);
    p4 = 1'b1;
    repeat (3) pres(16'h0200);
    rd8(8'h10, 8'h01);
    pres(16'h0200);
    rd8(8'h10, 8'h11);
    tick(20);
    rd8(8'h10, 8'h11);
    wr8(8'h10, 8'h00);
    p4 = 1'b0;
    pres(16'h0200);
    rd8(8'h10, 8'h11);
    wr8(8'h10, 8'h00);
    wr8(8'h04, 8'h04);
    pres(16'h0200);
    chk(pin, 1'b0);
    rd8(8'h10, 8'h11);
    rd8(8'h11, 8'h02);
    wr8(8'h10, 8'h00);
    tick(1);
    chk(pin, 1'b1);
    pres(16'h0040);
    rd8(8'h10, 8'h10);
    wr8(8'h10, 8'h00);
    wr16(8'h0A, 16'h1000);
    wr16(8'h0C, 16'h0100);
    wr8(8'h04, 8'h08);
    lres(16'h0800);
    rd8(8'h10, 8'h01);
    lres(16'h2000);
    chk(pin, 1'b0);
    wr8(8'h04, 8'h00);
    rd8(8'h10, 8'h21);
    wr8(8'h10, 8'h00);
    rd8(8'h10, 8'h01);
    wr8(8'h04, 8'h8D);
    lres(16'h0050);
    chk(pin, 1'b1);
    pres(16'h0200);
    chk(pin, 1'b0);
    wr8(8'h10, 8'h00);
    tick(1);
    chk(pin, 1'b1);
    wr8(8'h05, 8'h01);
    rd8(8'h05, 8'h01);
    ws = 1'b1;
    tick(1);
    ws = 1'b0;
    n = 1;
    while (wdone !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'h0005);
    tick(1);
    chk(wdone, 1'b0);
    close_out();
  end
endmodule // prox_light_interrupt_logic_bench
